// [shared/tpwm_pkg.sv]
// package of register map, field layout and encodings for the 8-bit pwm timer
package tpwm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_COMPARE = 4'h4;
    localparam logic [3:0] OFS_COUNTER = 4'h8;
    localparam logic [3:0] OFS_STATUS  = 4'hC;

    ////////////////////////////////////////////////////////////////////////////
    // ctrl field positions
    localparam int CTRL_WGM_LSB = 0;   // waveform_mode_select [1:0]
    localparam int CTRL_COM_LSB = 4;   // compare_output_mode [5:4]
    localparam int CTRL_CS_LSB  = 8;   // clock select [10:8]
    localparam int CTRL_DIR_BIT = 12;  // pin direction, 1 = output

    // status field positions
    localparam int STAT_TOV_BIT = 0;
    localparam int STAT_OC_BIT  = 1;
    localparam int STAT_DN_BIT  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [1:0] RST_WGM     = 2'h0;
    localparam logic [1:0] RST_COM     = 2'h0;
    localparam logic [2:0] RST_CS      = 3'h0;
    localparam logic [7:0] RST_COMPARE = 8'h00;
    localparam logic [7:0] RST_COUNTER = 8'h00;

    // counter extremes
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////
    // waveform modes (mode 2 behaves as normal)
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE  = 2'h1;
    localparam logic [1:0] WGM_FAST   = 2'h3;

    // compare output modes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV    = 2'h3;

    // prescaler: codes 1..7 give /1 /8 /32 /64 /128 /256 /1024, 0 stops
    localparam int         PRE_WIDTH = 10;
    localparam logic [9:0] PRE_MASK8    = 10'h007;
    localparam logic [9:0] PRE_MASK32   = 10'h01F;
    localparam logic [9:0] PRE_MASK64   = 10'h03F;
    localparam logic [9:0] PRE_MASK128  = 10'h07F;
    localparam logic [9:0] PRE_MASK256  = 10'h0FF;
    localparam logic [9:0] PRE_MASK1024 = 10'h3FF;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tpwm_pkg

// [hdl/tpwm_prescaler.sv]
// prescaler producing the one-cycle timer clock enable
module tpwm_prescaler (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] clock_select,
    output logic            tick
);

    logic [tpwm_pkg::PRE_WIDTH-1:0] div_count;
    logic [tpwm_pkg::PRE_WIDTH-1:0] mask;
    logic                           next_tick;

    // divide by the selected factor; code 0 stops the timer
    always_comb begin
        case (clock_select)
            3'h2:    mask = tpwm_pkg::PRE_MASK8;
            3'h3:    mask = tpwm_pkg::PRE_MASK32;
            3'h4:    mask = tpwm_pkg::PRE_MASK64;
            3'h5:    mask = tpwm_pkg::PRE_MASK128;
            3'h6:    mask = tpwm_pkg::PRE_MASK256;
            default: mask = tpwm_pkg::PRE_MASK1024;
        endcase
    end

    assign next_tick = (clock_select == 3'h1) ||
                       ((clock_select != 3'h0) && ((div_count & mask) == mask));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_count <= '0;
            tick      <= 1'b0;
        end else begin
            div_count <= div_count + 1'b1;
            tick      <= next_tick;
        end
    end

endmodule // tpwm_prescaler

// [hdl/tpwm_timer.sv]
// 8-bit timer with fast and phase correct pwm on one compare channel, axi4-lite registers
//
// Behaviour
// - in fast pwm the overflow flag is set each time the counter wraps from max to bottom.
// - in fast pwm compare-output mode two gives non-inverted and three inverted pwm.
// - the waveform reaches the pin only while the pin direction is output.
// - fast pwm changes the output at compare match and applies the opposite level at the max-to-bottom wrap.
// - the fast pwm period is 256 timer clocks, the timer clock being the bus clock over 1 to 1024.
// - a compare value at bottom gives a one-timer-clock spike once per 256 timer clocks in fast pwm.
// - a compare value at max gives a constant output level chosen by the polarity in fast pwm.
// - compare-output mode one toggles the output on each compare match in fast pwm.
// - in the pwm modes the compare value is double buffered and takes effect only at max; normal mode loads it every timer clock.
// - waveform mode value one selects phase correct pwm.
// - phase correct mode counts up from bottom to max then down to bottom repeatedly.
// - phase correct non-inverting clears on an up-count match and sets on a down-count match, inverting the opposite.
// - phase correct resolution is fixed at eight bits with no programmable top.
// - the counter stays at max for exactly one timer clock before turning down.
module tpwm_timer (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             compare_output_pin,
    output logic             compare_output_pin_oen_n,
    output logic             timer_overflow_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [1:0]  waveform_mode_select;
    logic [1:0]  compare_output_mode;
    logic [2:0]  clock_select;
    logic        pin_dir_out;
    logic [7:0]  compare_buffer;
    logic [7:0]  compare_value_reg;
    logic [7:0]  counter_value;
    logic        count_down;
    logic        oc_level;
    logic        tick;

    logic        aw_hold;
    logic        w_hold;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    ////////////////////////////////////////////////////////////////////////////
    // timer clock enable

    tpwm_prescaler u_prescaler (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .clock_select (clock_select),
        .tick         (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire wr_fire     = aw_hold && w_hold && !s_axi_bvalid;
    wire wr_ctrl     = wr_fire && (aw_addr == tpwm_pkg::OFS_CTRL);
    wire wr_compare  = wr_fire && (aw_addr == tpwm_pkg::OFS_COMPARE) && w_strb[0];
    wire wr_counter  = wr_fire && (aw_addr == tpwm_pkg::OFS_COUNTER) && w_strb[0];
    wire wr_status   = wr_fire && (aw_addr == tpwm_pkg::OFS_STATUS) && w_strb[0];
    wire wr_mapped   = (aw_addr == tpwm_pkg::OFS_CTRL) || (aw_addr == tpwm_pkg::OFS_COMPARE) ||
                       (aw_addr == tpwm_pkg::OFS_COUNTER) || (aw_addr == tpwm_pkg::OFS_STATUS);
    wire tov_clear   = wr_status && w_data[tpwm_pkg::STAT_TOV_BIT];

    wire rd_fire     = s_axi_arvalid && s_axi_arready;
    wire rd_ctrl     = (s_axi_araddr == tpwm_pkg::OFS_CTRL);
    wire rd_compare  = (s_axi_araddr == tpwm_pkg::OFS_COMPARE);
    wire rd_counter  = (s_axi_araddr == tpwm_pkg::OFS_COUNTER);
    wire rd_status   = (s_axi_araddr == tpwm_pkg::OFS_STATUS);
    wire rd_mapped   = rd_ctrl || rd_compare || rd_counter || rd_status;

    wire [31:0] ctrl_word = {19'h0, pin_dir_out, 1'b0, clock_select,
                             2'h0, compare_output_mode, 2'h0, waveform_mode_select};
    wire [31:0] stat_word = {29'h0, count_down, oc_level, timer_overflow_flag};
    wire [31:0] rd_word   = rd_ctrl    ? ctrl_word :
                            rd_compare ? {24'h0, compare_buffer} :
                            rd_counter ? {24'h0, counter_value} :
                            rd_status  ? stat_word : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // mode decode and counter step

    wire mode_fast  = (waveform_mode_select == tpwm_pkg::WGM_FAST);
    wire mode_phase = (waveform_mode_select == tpwm_pkg::WGM_PHASE);
    wire at_max     = (counter_value == tpwm_pkg::CNT_MAX);
    wire at_bottom  = (counter_value == tpwm_pkg::CNT_BOTTOM);
    wire match      = (counter_value == compare_value_reg);

    // phase correct turns at max and at bottom; max is held for a single tick
    wire next_down  = mode_phase && (at_max ? 1'b1 : (at_bottom ? 1'b0 : count_down));
    wire [7:0] next_count = (mode_phase && next_down) ? counter_value - 8'h01
                                                      : counter_value + 8'h01;

    // update point of the compare buffer: max in fast and phase correct, every tick in normal mode
    wire load_point = !(mode_fast || mode_phase) || at_max;

    // overflow event: fast and normal wrap at max, phase correct at bottom
    wire tov_event  = tick && (mode_phase ? at_bottom : at_max);

    // phase correct compares the value the counter steps to, so the match lands in the right slope
    wire pc_match   = (next_count == compare_value_reg);
    wire inv        = (compare_output_mode == tpwm_pkg::COM_INV);

    logic next_oc;
    always_comb begin
        next_oc = oc_level;
        if (mode_fast) begin
            if (compare_output_mode == tpwm_pkg::COM_TOGGLE) begin
                if (match) begin
                    next_oc = !oc_level;
                end
            end else if (compare_output_mode[1]) begin
                // match beats the wrap, so max gives a steady level and bottom a one-tick spike
                if (match) begin
                    next_oc = inv;
                end else if (at_max) begin
                    next_oc = !inv;
                end
            end
        end else if (mode_phase && compare_output_mode[1]) begin
            if (pc_match) begin
                next_oc = next_down ? !inv : inv;
            end
        end else if (compare_output_mode == tpwm_pkg::COM_TOGGLE && match) begin
            next_oc = !oc_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waveform_mode_select <= tpwm_pkg::RST_WGM;
            compare_output_mode  <= tpwm_pkg::RST_COM;
            clock_select         <= tpwm_pkg::RST_CS;
            pin_dir_out          <= 1'b0;
            compare_buffer       <= tpwm_pkg::RST_COMPARE;
        end else begin
            if (wr_ctrl && w_strb[0]) begin
                waveform_mode_select <= w_data[tpwm_pkg::CTRL_WGM_LSB +: 2];
                compare_output_mode  <= w_data[tpwm_pkg::CTRL_COM_LSB +: 2];
            end
            if (wr_ctrl && w_strb[1]) begin
                clock_select <= w_data[tpwm_pkg::CTRL_CS_LSB +: 3];
                pin_dir_out  <= w_data[tpwm_pkg::CTRL_DIR_BIT];
            end
            if (wr_compare) begin
                compare_buffer <= w_data[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter, compare and waveform

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_value     <= tpwm_pkg::RST_COUNTER;
            compare_value_reg <= tpwm_pkg::RST_COMPARE;
            count_down        <= 1'b0;
            oc_level          <= 1'b0;
        end else if (wr_counter) begin
            // a software write of the count wins over a tick in the same cycle
            counter_value <= w_data[7:0];
        end else if (tick) begin
            counter_value <= next_count;
            count_down    <= next_down;
            oc_level      <= next_oc;
            if (load_point) begin
                compare_value_reg <= compare_buffer;
            end
        end
    end

    // set wins over a same-cycle clear so no overflow is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_overflow_flag <= 1'b0;
        end else if (tov_event) begin
            timer_overflow_flag <= 1'b1;
        end else if (tov_clear) begin
            timer_overflow_flag <= 1'b0;
        end
    end

    // pin released while the direction is input, so the waveform cannot leak out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_output_pin       <= 1'b0;
            compare_output_pin_oen_n <= 1'b1;
        end else begin
            compare_output_pin       <= pin_dir_out && oc_level;
            compare_output_pin_oen_n <= !pin_dir_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold       <= 1'b0;
            w_hold        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tpwm_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold       <= 1'b1;
                aw_addr       <= {s_axi_awaddr[3:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? tpwm_pkg::RESP_OKAY : tpwm_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= tpwm_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? tpwm_pkg::RESP_OKAY : tpwm_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // tpwm_timer

// [testbench/tpwm_timer_sva.sv]
// checker of bus handshakes, pin drive and overflow flag at the pwm timer ports
module tpwm_timer_sva (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        compare_output_pin,
    input wire logic        compare_output_pin_oen_n,
    input wire logic        timer_overflow_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////
    chk_pin_released: assert property (compare_output_pin_oen_n |-> !compare_output_pin)
        else $error("pin high while released");
    chk_dir_by_write: assert property ($changed(compare_output_pin_oen_n) |-> $past(s_axi_bvalid))
        else $error("pin direction changed without a register write");
    chk_flag_clear_write: assert property ($fell(timer_overflow_flag) |-> $rose(s_axi_bvalid))
        else $error("overflow flag dropped without a write");
    chk_reset_idle_state: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid
        && !s_axi_rvalid && compare_output_pin_oen_n && !compare_output_pin && !timer_overflow_flag)
        else $error("outputs not idle after reset");
    // the register lands one edge after both halves are taken, and bvalid shows after that edge
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 (s_axi_bvalid && s_axi_bresp == tpwm_pkg::RESP_OKAY))
        else $error("write response late or wrong");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write accepted while response pending");
endmodule // tpwm_timer_sva

// [testbench/tpwm_pin_load.sv]
// behavioural load on the compare output pin
module tpwm_pin_load (
    input  wire logic aclk,
    input  wire logic pin,
    input  wire logic pin_oen_n,
    output logic      level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q = 1'h0;
    // no pull on the line: a released pin shows the inverse of its last driven level, never a held value
    always @(posedge aclk) begin
        if (!pin_oen_n) begin
            last_q <= pin;
        end
    end
    assign level = pin_oen_n ? !last_q : pin;
endmodule // tpwm_pin_load

// [testbench/testbench.sv]
// self-checking bench for the pwm timer: waveform table, then buffer, flag and dual-slope cases
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [1:0] wgm; logic [1:0] com; logic [2:0] cs; logic dir; logic [7:0] cmp;
        int win; int high; int rises;} tpwm_row_t;
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, late_ready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic        compare_output_pin, compare_output_pin_oen_n, timer_overflow_flag, load_level;
    int          bad_count = 0, num_checks = 0, h, r, n;
    time         t0, t1;
    tpwm_row_t   rows [10] = '{
        '{tpwm_pkg::WGM_FAST, tpwm_pkg::COM_NONINV, 3'h1, 1'h1, 8'h80, 512, 258, 2},
        '{tpwm_pkg::WGM_FAST, tpwm_pkg::COM_INV, 3'h1, 1'h1, 8'h80, 512, 254, 2},
        '{tpwm_pkg::WGM_FAST, tpwm_pkg::COM_NONINV, 3'h1, 1'h1, 8'h00, 512, 2, 2},
        '{tpwm_pkg::WGM_FAST, tpwm_pkg::COM_NONINV, 3'h1, 1'h1, 8'hFF, 512, 0, 0},
        '{tpwm_pkg::WGM_FAST, tpwm_pkg::COM_INV, 3'h1, 1'h1, 8'hFF, 512, 512, 0},
        '{tpwm_pkg::WGM_FAST, tpwm_pkg::COM_TOGGLE, 3'h1, 1'h1, 8'h10, 512, 256, 1},
        '{tpwm_pkg::WGM_PHASE, tpwm_pkg::COM_NONINV, 3'h1, 1'h1, 8'h40, 1020, 256, 2},
        '{tpwm_pkg::WGM_PHASE, tpwm_pkg::COM_INV, 3'h1, 1'h1, 8'h40, 1020, 764, 2},
        '{tpwm_pkg::WGM_FAST, tpwm_pkg::COM_NONINV, 3'h2, 1'h1, 8'h80, 4096, 2064, 2},
        '{tpwm_pkg::WGM_FAST, tpwm_pkg::COM_INV, 3'h1, 1'h0, 8'hFF, 512, 0, 0}};

    tpwm_timer uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compare_output_pin,
        .compare_output_pin_oen_n, .timer_overflow_flag);
    tpwm_pin_load load (.aclk, .pin(compare_output_pin), .pin_oen_n(compare_output_pin_oen_n), .level(load_level));

    always #4 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // bready and rready go up with the request; late_ready holds them back until the answer shows,
    // so the hold-until-taken path is exercised too
    task automatic axi_write(input logic [3:0] a, input logic [31:0] v);
        logic done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= !late_ready;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            done = s_axi_bvalid && s_axi_bready;
            if (s_axi_bvalid) s_axi_bready <= !done;
        end while (!done);
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] v);
        logic done;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= !late_ready;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            done = s_axi_rvalid && s_axi_rready;
            v = s_axi_rdata;
            if (s_axi_rvalid) s_axi_rready <= !done;
        end while (!done);
        check(s_axi_rresp, tpwm_pkg::RESP_OKAY);
    endtask

    task automatic measure(input int win, output int high, output int rises);
        logic prev;
        prev = compare_output_pin;
        high = 0;
        rises = 0;
        repeat (win) begin
            @(posedge aclk);
            if (compare_output_pin === 1'h1) high++;
            if (prev === 1'h0 && compare_output_pin === 1'h1) rises++;
            if (compare_output_pin_oen_n === 1'h0) check(load_level, compare_output_pin);
            prev = compare_output_pin;
        end
    endtask

    task automatic wait_on(ref logic s, input logic v, output time t);
        int k;
        k = 0;
        while (s !== v && k < 3000) begin
            @(posedge aclk);
            k++;
        end
        t = $time;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (80000) @(posedge aclk);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        check({timer_overflow_flag, compare_output_pin, compare_output_pin_oen_n}, 3'h1);
        axi_read(tpwm_pkg::OFS_CTRL, d);
        check(d, 32'h0000_0000);
        foreach (rows[i]) begin
            axi_write(tpwm_pkg::OFS_COMPARE, {24'h00_0000, rows[i].cmp});
            axi_write(tpwm_pkg::OFS_CTRL, {19'h0_0000, rows[i].dir, 1'h0, rows[i].cs, 2'h0, rows[i].com, 2'h0,
                rows[i].wgm});
            repeat (2 * rows[i].win) @(posedge aclk);
            check(compare_output_pin_oen_n, !rows[i].dir);
            measure(rows[i].win, h, r);
            check(h, rows[i].high);
            check(r, rows[i].rises);
        end
        // slow master until the second reset; new compare written mid-pulse must wait for the period boundary
        late_ready = 1'h1;
        axi_write(tpwm_pkg::OFS_COMPARE, 32'h0000_0080);
        axi_write(tpwm_pkg::OFS_CTRL, 32'h0000_1123);
        repeat (600) @(posedge aclk);
        wait_on(compare_output_pin, 1'h0, t0);
        wait_on(compare_output_pin, 1'h1, t0);
        repeat (20) @(posedge aclk);
        axi_write(tpwm_pkg::OFS_COMPARE, 32'h0000_0010);
        wait_on(compare_output_pin, 1'h0, t1);
        check(32'((t1 - t0) / 8), 129);
        wait_on(compare_output_pin, 1'h1, t0);
        wait_on(compare_output_pin, 1'h0, t1);
        check(32'((t1 - t0) / 8), 17);
        axi_write(tpwm_pkg::OFS_STATUS, 32'h0000_0001);
        wait_on(timer_overflow_flag, 1'h1, t0);
        axi_write(tpwm_pkg::OFS_STATUS, 32'h0000_0001);
        wait_on(timer_overflow_flag, 1'h1, t1);
        check(32'((t1 - t0) / 8), 256);
        axi_read(tpwm_pkg::OFS_STATUS, d);
        check(d[tpwm_pkg::STAT_TOV_BIT], 1'h1);
        late_ready = 1'h0;
        // second reset mid-run, then the turn at the top of the dual slope
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        axi_write(tpwm_pkg::OFS_CTRL, 32'h0000_0701);
        axi_write(tpwm_pkg::OFS_COUNTER, 32'h0000_00FE);
        n = 0;
        do begin
            axi_read(tpwm_pkg::OFS_COUNTER, d);
            n++;
        end while (d !== 32'h0000_00FF && n < 2000);
        t0 = $time;
        do begin
            axi_read(tpwm_pkg::OFS_COUNTER, d);
            n++;
        end while (d === 32'h0000_00FF && n < 4000);
        t1 = $time;
        check(d, 32'h0000_00FE);
        check(32'(((t1 - t0) / 8 + 8) / 16), 64);
        axi_read(tpwm_pkg::OFS_STATUS, d);
        check(d[tpwm_pkg::STAT_DN_BIT], 1'h1);
        complete_run();
    end
endmodule // testbench

bind tpwm_timer tpwm_timer_sva chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .compare_output_pin, .compare_output_pin_oen_n, .timer_overflow_flag);
